// ---- verilog/jts_top.sv ----
/*
 * Test and debug access port: three controllers in one chain, test data
 * output stage, crossings to the core clock, and the debug sync pin.
 * Assumes tck comes from an external host and may stop between scans; the
 * core side keeps its status inputs quasi-static across a scan.
 *
 * // Function
 * // After reset the chain holds debug, boundary scan and processor controllers.
 * // Boundary scan controller follows standard rules and scans the pins.
 * // Debug controller gives scan access into the peripherals and converter.
 * // Processor controller reaches processing tile, switch and programmable memory.
 * // Five consecutive test clocks with mode select high reset the test logic.
 * // In output mode the sync pin floats until a breakpoint, then drives low.
 * In input mode a falling sync pin puts the processor into debug.
 * // Software picks whether the sync pin is input, output or unused.
 * // Identification register: version, part, maker, bit zero one.
 * // User code register: user identifier, unused field, silicon revision.
 * // User identifier comes from programmable security bits, zero when blank.
 * // Each controller is the standard sixteen-state machine shifting on test clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "jts_params.svh"

module jts_top
   import jts_pkg::*;
#(
   parameter int DBG_AW = 16,
   parameter int PRC_AW = 32,
   parameter int BSC_W = 8,
   // Identification values below are arbitrary.
   parameter logic [31:0] DBG_DEVICE_IDENTIFICATION = 32'h1000_0A01,
   parameter logic [31:0] BSC_DEVICE_IDENTIFICATION = 32'h1000_0B01,
   parameter logic [31:0] PRC_DEVICE_IDENTIFICATION = 32'h1000_0C01,
   parameter logic [`JTS_REV_W-1:0] SILICON_REV = 16'h0001
) (
   // Core clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Test link.
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Debug synchronisation pin, active low, open drain.
   input wire logic dbg_sync_n_in,
   output logic dbg_sync_n_out,
   output logic dbg_sync_n_oe,
   // Processor debug control.
   input wire jts_dbg_mode_t dbg_mode,
   input wire logic breakpoint_hit,
   input wire logic debug_resume,
   output logic debug_req,
   // Programmable security register user identifier field.
   input wire logic [`JTS_UID_W-1:0] user_identifier_field,
   // Peripheral access.
   input wire logic [DBG_AW-1:0] periph_status,
   output logic [DBG_AW-1:0] periph_word,
   output logic periph_stb,
   // Processor, switch and memory access.
   input wire logic [PRC_AW-1:0] proc_status,
   output logic [PRC_AW-1:0] proc_word,
   output logic proc_stb,
   // Boundary scan cells.
   input wire logic [BSC_W-1:0] bscan_in,
   output logic [BSC_W-1:0] bscan_out,
   output logic bscan_extest
);
   localparam int CW = `JTS_UID_W + DBG_AW + PRC_AW + BSC_W;

   // Link domain signals.
   logic rst_t1_ff, rst_t2_ff;
   logic [CW-1:0] cap_t1_ff, cap_t2_ff;
   logic [`JTS_UID_W-1:0] uid_t;
   logic [31:0] usercode_w;
   logic tdo_dbg, tdo_bsc, tdo_prc;
   logic [2:0] shift_w, rst_w, tgl_w;
   logic ext_t;
   logic [DBG_AW-1:0] dbg_upd;
   logic [BSC_W-1:0] bsc_upd;
   logic [PRC_AW-1:0] prc_upd;
   logic tdo_ff, tdo_oe_ff;
   logic [2:0] hi_cnt_ff;

   // Core domain signals.
   logic [2:0] tg1_ff, tg2_ff, tg3_ff;
   logic ex1_ff, ex2_ff;
   logic dp1_ff, dp2_ff, dp3_ff;
   logic [DBG_AW-1:0] periph_word_ff, nxt_periph_word;
   logic [PRC_AW-1:0] proc_word_ff, nxt_proc_word;
   logic [BSC_W-1:0] bscan_out_ff, nxt_bscan_out;
   logic periph_stb_ff, nxt_periph_stb, proc_stb_ff, nxt_proc_stb;
   logic dbg_oe_ff, nxt_dbg_oe, debug_req_ff, nxt_debug_req;
   logic dbg_out_ff;
   logic [2:0] upd_edge;

   // Core reset and quasi-static core inputs enter the link domain twice registered.
   always_ff @(posedge tck) begin
      rst_t1_ff <= rst;
      rst_t2_ff <= rst_t1_ff;
      cap_t1_ff <= {user_identifier_field, periph_status, proc_status, bscan_in};
      cap_t2_ff <= cap_t1_ff;
   end

   // User code: identifier on top, unused field zero, revision below.
   assign uid_t = cap_t2_ff[CW-1 -: `JTS_UID_W];
   assign usercode_w = {uid_t, {`JTS_UNUSED_W{1'b0}}, SILICON_REV};

   // Chain from the input pin: debug, boundary scan, processor, output pin.
   jts_tap #(.AW(DBG_AW), .DEVICE_IDENTIFICATION(DBG_DEVICE_IDENTIFICATION)) u_dbg_tap (
      .tck(tck), .trst(rst_t2_ff), .tms(tms), .tdi(tdi), .tdo(tdo_dbg),
      .shifting(shift_w[0]), .in_reset(rst_w[0]), .usercode(usercode_w),
      .acc_cap(cap_t2_ff[PRC_AW+BSC_W +: DBG_AW]),
      .acc_upd(dbg_upd), .acc_tgl(tgl_w[0]), .extest());
   jts_tap #(.AW(BSC_W), .DEVICE_IDENTIFICATION(BSC_DEVICE_IDENTIFICATION)) u_bsc_tap (
      .tck(tck), .trst(rst_t2_ff), .tms(tms), .tdi(tdo_dbg), .tdo(tdo_bsc),
      .shifting(shift_w[1]), .in_reset(rst_w[1]), .usercode(usercode_w),
      .acc_cap(cap_t2_ff[BSC_W-1:0]),
      .acc_upd(bsc_upd), .acc_tgl(tgl_w[1]), .extest(ext_t));
   jts_tap #(.AW(PRC_AW), .DEVICE_IDENTIFICATION(PRC_DEVICE_IDENTIFICATION)) u_prc_tap (
      .tck(tck), .trst(rst_t2_ff), .tms(tms), .tdi(tdo_bsc), .tdo(tdo_prc),
      .shifting(shift_w[2]), .in_reset(rst_w[2]), .usercode(usercode_w),
      .acc_cap(cap_t2_ff[BSC_W +: PRC_AW]),
      .acc_upd(prc_upd), .acc_tgl(tgl_w[2]), .extest());

   // Output pin changes on the falling test clock edge, driven only while shifting.
   always_ff @(negedge tck) begin
      if (rst_t2_ff) begin
         tdo_ff <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else begin
         tdo_ff <= tdo_prc;
         tdo_oe_ff <= shift_w[2];
      end
   end

   // Count of consecutive high mode-select edges, read only by the checks.
   always_ff @(posedge tck) begin
      if (rst_t2_ff || !tms) begin
         hi_cnt_ff <= 3'h0;
      end else if (hi_cnt_ff != 3'h7) begin
         hi_cnt_ff <= hi_cnt_ff + 3'h1;
      end
   end

   // Update toggles, the boundary drive mode and the sync pin enter the core domain.
   always_ff @(posedge core_clk) begin
      tg1_ff <= tgl_w;
      tg2_ff <= tg1_ff;
      tg3_ff <= tg2_ff;
      ex1_ff <= ext_t;
      ex2_ff <= ex1_ff;
      dp1_ff <= dbg_sync_n_in;
      dp2_ff <= dp1_ff;
      dp3_ff <= dp2_ff;
   end

   // Words are taken once their toggle has crossed; they stay put until the next scan.
   assign upd_edge = tg2_ff ^ tg3_ff;
   always_comb begin
      nxt_periph_word = upd_edge[0] ? dbg_upd : periph_word_ff;
      nxt_bscan_out = upd_edge[1] ? bsc_upd : bscan_out_ff;
      nxt_proc_word = upd_edge[2] ? prc_upd : proc_word_ff;
      nxt_periph_stb = upd_edge[0];
      nxt_proc_stb = upd_edge[2];
   end

   // Access word registers.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         periph_word_ff <= '0;
         bscan_out_ff <= '0;
         proc_word_ff <= '0;
         periph_stb_ff <= 1'b0;
         proc_stb_ff <= 1'b0;
      end else begin
         periph_word_ff <= nxt_periph_word;
         bscan_out_ff <= nxt_bscan_out;
         proc_word_ff <= nxt_proc_word;
         periph_stb_ff <= nxt_periph_stb;
         proc_stb_ff <= nxt_proc_stb;
      end
   end

   // Sync pin: drive low from a breakpoint until resume; a falling input requests debug.
   always_comb begin
      nxt_dbg_oe = dbg_oe_ff;
      if (dbg_mode != JTS_DBG_OUT || debug_resume) begin
         nxt_dbg_oe = 1'b0;
      end
      if (dbg_mode == JTS_DBG_OUT && breakpoint_hit) begin
         nxt_dbg_oe = 1'b1;
      end
      nxt_debug_req = (dbg_mode == JTS_DBG_IN) && dp3_ff && !dp2_ff;
   end

   // Sync pin registers; the pin level itself is always low when enabled.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dbg_oe_ff <= 1'b0;
         debug_req_ff <= 1'b0;
         dbg_out_ff <= 1'b0;
      end else begin
         dbg_oe_ff <= nxt_dbg_oe;
         debug_req_ff <= nxt_debug_req;
         dbg_out_ff <= 1'b0;
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe = tdo_oe_ff;
   assign dbg_sync_n_out = dbg_out_ff;
   assign dbg_sync_n_oe = dbg_oe_ff;
   assign debug_req = debug_req_ff;
   assign periph_word = periph_word_ff;
   assign periph_stb = periph_stb_ff;
   assign proc_word = proc_word_ff;
   assign proc_stb = proc_stb_ff;
   assign bscan_out = bscan_out_ff;
   assign bscan_extest = ex2_ff;

   // Link side checks run on the test clock and rest while the link reset stands.

   // Five high mode-select edges reach the reset state
   // from anywhere in the walk.
   chk_tms_reset: assert property (@(posedge tck) disable iff (rst_t2_ff)
      hi_cnt_ff >= `JTS_RESET_TMS_HIGH |-> &rst_w)
      else $error("five high mode cycles did not reset the chain");

   // Releasing the link reset leaves all three
   // controllers in their reset state.
   chk_chain_reset: assert property (@(posedge tck) disable iff (rst_t2_ff)
      $fell(rst_t2_ff) |-> &rst_w)
      else $error("chain not in reset after reset release");

   // The user identifier reaches the user code
   // two test clocks after it is sampled.
   chk_uid_source: assert property (@(posedge tck) disable iff (rst_t2_ff)
      !$past(rst_t2_ff, 2) |->
      usercode_w[`JTS_ID_W-1 -: `JTS_UID_W] == $past(user_identifier_field, 2))
      else $error("user identifier not taken from the security bits");

   // Core side checks run on the core clock.

   // A breakpoint in output mode pulls the pin low
   // on the next core edge.
   chk_dbg_drive_low: assert property (@(posedge core_clk) disable iff (rst)
      dbg_mode == JTS_DBG_OUT && breakpoint_hit |=> dbg_sync_n_oe && !dbg_sync_n_out)
      else $error("sync pin not driven low at breakpoint");

   // Without a breakpoint the pin stays released.
   chk_dbg_tristate: assert property (@(posedge core_clk) disable iff (rst)
      !dbg_sync_n_oe && !(dbg_mode == JTS_DBG_OUT && breakpoint_hit) |=> !dbg_sync_n_oe)
      else $error("sync pin driven before breakpoint");

   // Once driven, the pin stays low until resume
   // or a change of mode.
   chk_dbg_hold: assert property (@(posedge core_clk) disable iff (rst)
      dbg_sync_n_oe && dbg_mode == JTS_DBG_OUT && !debug_resume |=> dbg_sync_n_oe)
      else $error("sync pin released before resume");

   // An unused pin neither drives nor requests.
   chk_dbg_mode_off: assert property (@(posedge core_clk) disable iff (rst)
      dbg_mode == JTS_DBG_NONE |=> !dbg_sync_n_oe && !debug_req)
      else $error("sync pin active while unused");

   // A falling synced pin in input mode requests debug.
   chk_dbg_req_in: assert property (@(posedge core_clk) disable iff (rst)
      dbg_mode == JTS_DBG_IN && dp3_ff && !dp2_ff |=> debug_req)
      else $error("low sync pin did not request debug");

   // A debug request lasts a single core cycle.
   chk_req_pulse: assert property (@(posedge core_clk) disable iff (rst)
      debug_req |=> !debug_req)
      else $error("debug request longer than one cycle");

   // A peripheral strobe carries the crossed word.
   chk_periph_update: assert property (@(posedge core_clk) disable iff (rst)
      periph_stb |-> periph_word == $past(dbg_upd) && !$past(periph_stb))
      else $error("peripheral word not taken on strobe");

   // A processor strobe carries the crossed word.
   chk_proc_word: assert property (@(posedge core_clk) disable iff (rst)
      proc_stb |-> proc_word == $past(prc_upd))
      else $error("processor word not taken on strobe");

   // Each processor update gives one strobe cycle.
   chk_proc_update: assert property (@(posedge core_clk) disable iff (rst)
      $changed(tg2_ff[2]) |=> proc_stb ##1 !proc_stb)
      else $error("processor strobe missing or too long");

   // The boundary word follows its crossed update.
   chk_bscan_word: assert property (@(posedge core_clk) disable iff (rst)
      upd_edge[1] |=> bscan_out == $past(bsc_upd))
      else $error("boundary word not taken after update");

   // The boundary drive mode follows the controller.
   chk_bscan_mode: assert property (@(posedge core_clk) disable iff (rst)
      ex1_ff |=> bscan_extest)
      else $error("boundary drive mode did not follow");

   // Main scenarios worth seeing in a run.
   cov_dbg_drive: cover property (@(posedge core_clk) disable iff (rst) $rose(dbg_sync_n_oe));
   cov_dbg_req: cover property (@(posedge core_clk) disable iff (rst) debug_req);
   cov_periph_stb: cover property (@(posedge core_clk) disable iff (rst) periph_stb);
   cov_proc_stb: cover property (@(posedge core_clk) disable iff (rst) proc_stb);
   cov_tms_reset: cover property (@(posedge tck) disable iff (rst_t2_ff)
      hi_cnt_ff == `JTS_RESET_TMS_HIGH);
endmodule
`default_nettype wire

// ---- verilog/jts_params.svh ----
/*
 * Constants of the test access port chain: instruction codes, register field
 * positions and widths, and the reset sequence length.
 * Assumes nothing; included by the package and the design files.
 */
`ifndef JTS_PARAMS_SVH
`define JTS_PARAMS_SVH

// Instruction register width and codes.
`define JTS_IR_W 4
`define JTS_IR_EXTEST 4'h0
`define JTS_IR_DEVICE_IDENTIFICATION 4'h1
`define JTS_IR_USERCODE 4'h2
`define JTS_IR_SAMPLE 4'h3
`define JTS_IR_ACCESS 4'h8
`define JTS_IR_BYPASS 4'hF
`define JTS_IR_CAPTURE 4'h1

// Identification and user code layout.
`define JTS_ID_W 32
`define JTS_UID_W 10
`define JTS_UID_LSB 22
`define JTS_UNUSED_W 6
`define JTS_REV_W 16

// Consecutive high test mode cycles that force the reset state.
`define JTS_RESET_TMS_HIGH 3'h5

`endif

// ---- verilog/jts_pkg.sv ----
/*
 * Types of the test access port chain: controller states and the modes of
 * the debug synchronisation pin.
 * Assumes jts_params.svh is on the include path.
 */
`include "jts_params.svh"

package jts_pkg;
   // Sixteen controller states.
   typedef enum logic [3:0] {
      JTS_TLR, JTS_RTI, JTS_SEL_DR, JTS_CAP_DR, JTS_SH_DR, JTS_EX1_DR, JTS_PA_DR,
      JTS_EX2_DR, JTS_UPD_DR, JTS_SEL_IR, JTS_CAP_IR, JTS_SH_IR, JTS_EX1_IR,
      JTS_PA_IR, JTS_EX2_IR, JTS_UPD_IR
   } jts_tap_state_t;

   // Behaviour of the debug synchronisation pin.
   typedef enum logic [1:0] {
      JTS_DBG_NONE, JTS_DBG_IN, JTS_DBG_OUT
   } jts_dbg_mode_t;
endpackage

// ---- verilog/jts_tap.sv ----
/*
 * One test access port controller: sixteen-state machine, instruction
 * register, bypass, identification, user code and one access register.
 * Assumes tck is the link clock and trst a level synchronous to it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "jts_params.svh"

module jts_tap
   import jts_pkg::*;
#(
   parameter int AW = 16,
   parameter logic [31:0] DEVICE_IDENTIFICATION = 32'h0000_0001
) (
   // Link side.
   input wire logic tck,
   input wire logic trst,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic shifting,
   output logic in_reset,
   // Identification.
   input wire logic [31:0] usercode,
   // Access register towards the reached logic.
   input wire logic [AW-1:0] acc_cap,
   output logic [AW-1:0] acc_upd,
   output logic acc_tgl,
   output logic extest
);
   localparam int DW = (AW > `JTS_ID_W) ? AW : `JTS_ID_W;

   jts_tap_state_t state_ff, nxt_state;
   logic [`JTS_IR_W-1:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
   logic [DW-1:0] dr_ff, nxt_dr;
   logic [AW-1:0] upd_ff, nxt_upd;
   logic tgl_ff, nxt_tgl;
   logic acc_sel;
   int len;

   // Selected data register length follows the current instruction.
   function automatic int dr_len(input logic [`JTS_IR_W-1:0] ir);
      if (ir == `JTS_IR_DEVICE_IDENTIFICATION || ir == `JTS_IR_USERCODE) begin
         return `JTS_ID_W;
      end else if (ir == `JTS_IR_ACCESS || ir == `JTS_IR_SAMPLE || ir == `JTS_IR_EXTEST) begin
         return AW;
      end
      return 1;
   endfunction

   assign acc_sel = (ir_ff == `JTS_IR_ACCESS) || (ir_ff == `JTS_IR_SAMPLE) || extest;
   assign extest = (ir_ff == `JTS_IR_EXTEST);
   assign tdo = (state_ff == JTS_SH_IR) ? ir_sh_ff[0] : dr_ff[0];
   assign shifting = (state_ff == JTS_SH_IR) || (state_ff == JTS_SH_DR);
   assign in_reset = (state_ff == JTS_TLR);
   assign acc_upd = upd_ff;
   assign acc_tgl = tgl_ff;

   // Controller walk and register shifting on each rising test clock edge.
   always_comb begin
      len = dr_len(ir_ff);
      nxt_state = state_ff;
      nxt_ir_sh = ir_sh_ff;
      nxt_ir = ir_ff;
      nxt_dr = dr_ff;
      nxt_upd = upd_ff;
      nxt_tgl = tgl_ff;
      unique case (state_ff)
         JTS_TLR: nxt_state = tms ? JTS_TLR : JTS_RTI;
         JTS_RTI: nxt_state = tms ? JTS_SEL_DR : JTS_RTI;
         JTS_SEL_DR: nxt_state = tms ? JTS_SEL_IR : JTS_CAP_DR;
         JTS_CAP_DR: nxt_state = tms ? JTS_EX1_DR : JTS_SH_DR;
         JTS_SH_DR: nxt_state = tms ? JTS_EX1_DR : JTS_SH_DR;
         JTS_EX1_DR: nxt_state = tms ? JTS_UPD_DR : JTS_PA_DR;
         JTS_PA_DR: nxt_state = tms ? JTS_EX2_DR : JTS_PA_DR;
         JTS_EX2_DR: nxt_state = tms ? JTS_UPD_DR : JTS_SH_DR;
         JTS_UPD_DR: nxt_state = tms ? JTS_SEL_DR : JTS_RTI;
         JTS_SEL_IR: nxt_state = tms ? JTS_TLR : JTS_CAP_IR;
         JTS_CAP_IR: nxt_state = tms ? JTS_EX1_IR : JTS_SH_IR;
         JTS_SH_IR: nxt_state = tms ? JTS_EX1_IR : JTS_SH_IR;
         JTS_EX1_IR: nxt_state = tms ? JTS_UPD_IR : JTS_PA_IR;
         JTS_PA_IR: nxt_state = tms ? JTS_EX2_IR : JTS_PA_IR;
         JTS_EX2_IR: nxt_state = tms ? JTS_UPD_IR : JTS_SH_IR;
         JTS_UPD_IR: nxt_state = tms ? JTS_SEL_DR : JTS_RTI;
      endcase
      unique case (state_ff)
         JTS_TLR: nxt_ir = `JTS_IR_DEVICE_IDENTIFICATION;
         JTS_CAP_IR: nxt_ir_sh = `JTS_IR_CAPTURE;
         JTS_SH_IR: nxt_ir_sh = {tdi, ir_sh_ff[`JTS_IR_W-1:1]};
         JTS_UPD_IR: nxt_ir = ir_sh_ff;
         JTS_CAP_DR: begin
            nxt_dr = '0;
            if (ir_ff == `JTS_IR_DEVICE_IDENTIFICATION) begin
               nxt_dr[31:0] = DEVICE_IDENTIFICATION;
            end else if (ir_ff == `JTS_IR_USERCODE) begin
               nxt_dr[31:0] = usercode;
            end else if (acc_sel) begin
               nxt_dr[AW-1:0] = acc_cap;
            end
         end
         JTS_SH_DR: begin
            for (int i = 0; i < DW; i++) begin
               if (i == len - 1) begin
                  nxt_dr[i] = tdi;
               end else if (i < len - 1) begin
                  nxt_dr[i] = dr_ff[i+1];
               end
            end
         end
         JTS_UPD_DR: begin
            if (acc_sel) begin
               nxt_upd = dr_ff[AW-1:0];
               nxt_tgl = ~tgl_ff;
            end
         end
         default: ;
      endcase
   end

   // Registers of the controller; the link reset forces the reset state.
   always_ff @(posedge tck) begin
      if (trst) begin
         state_ff <= JTS_TLR;
         ir_sh_ff <= '0;
         ir_ff <= `JTS_IR_DEVICE_IDENTIFICATION;
         dr_ff <= '0;
         upd_ff <= '0;
         tgl_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ir_sh_ff <= nxt_ir_sh;
         ir_ff <= nxt_ir;
         dr_ff <= nxt_dr;
         upd_ff <= nxt_upd;
         tgl_ff <= nxt_tgl;
      end
   end

   default clocking tap_cb @(posedge tck); endclocking
   default disable iff (trst);

   chk_device_identification_capture: assert property (
      state_ff == JTS_CAP_DR && ir_ff == `JTS_IR_DEVICE_IDENTIFICATION |=> dr_ff[31:0] == DEVICE_IDENTIFICATION && dr_ff[0])
      else $error("identification value not captured");
   chk_usercode_capture: assert property (
      state_ff == JTS_CAP_DR && ir_ff == `JTS_IR_USERCODE |=> dr_ff[31:0] == $past(usercode))
      else $error("user code value not captured");
   chk_ir_capture: assert property (
      state_ff == JTS_CAP_IR |=> ir_sh_ff == `JTS_IR_CAPTURE)
      else $error("instruction capture value not loaded");
   chk_ir_shift: assert property (
      state_ff == JTS_SH_IR |=> ir_sh_ff == {$past(tdi), $past(ir_sh_ff[`JTS_IR_W-1:1])})
      else $error("instruction register did not shift");
endmodule
`default_nettype wire

// ---- bench/jts_host.sv ----
/*
 * Model of the external test link host: drives tck, tms and tdi.
 * Assumes every scan starts from Run-Test/Idle and tdo changes on falling tck.
 */
`timescale 1ns/10ps
`default_nettype none
module jts_host (
   // Link.
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   // Scan result.
   output logic scan_done,
   output logic [95:0] scan_out
);
   logic last_q;
   // Idle levels; tck stands still between frames.
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
      last_q = 1'h0;
      scan_done = 1'h0;
      scan_out = '0;
   end
   // One tck period; a released tdo reads as the inverse of its last level.
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #7.5;
      q = tdo_oe ? tdo : ~last_q;
      last_q = q;
      tck = 1'h1;
      #7.5;
      tck = 1'h0;
   endtask
   // High tms clocks force the reset state, then one low clock into idle.
   task automatic tms_reset(input int n);
      logic q;
      repeat (n) step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
      tdi = ~tdi;
   endtask
   // Instruction or data scan, LSB first, ending back in idle.
   task automatic scan(input logic ir, input int n, input logic [95:0] din);
      logic q;
      logic [95:0] dout;
      dout = '0;
      #3.3;
      step(1'h1, 1'h0, q);
      if (ir) begin
         step(1'h1, 1'h0, q);
      end
      step(1'h0, 1'h0, q);
      step(1'h0, 1'h0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
      tdi = ~tdi;
      scan_out = dout;
      scan_done = 1'h1;
      #1;
      scan_done = 1'h0;
   endtask
endmodule
`default_nettype wire

// ---- bench/jts_top_tb.sv ----
/*
 * Self-checking bench of the test access port chain.
 * Assumes the host model drives the link and a pull-up sits on the sync pin.
 */
`timescale 1ns/10ps
`default_nettype none
module jts_top_tb
   import jts_pkg::*;
;
   // Identification values are arbitrary.
   localparam logic [31:0] DBG_ID = 32'h2000_0A03;
   localparam logic [31:0] BSC_ID = 32'h2000_0B05;
   localparam logic [31:0] PRC_ID = 32'h2000_0C07;
   localparam logic [15:0] REV = 16'h00A5;
   logic core_clk, rst, tck, tms, tdi, tdo, tdo_oe, scan_done, ext_low;
   logic dbg_sync_n_out, dbg_sync_n_oe, breakpoint_hit, debug_resume, debug_req;
   logic periph_stb, proc_stb, bscan_extest;
   logic [9:0] uid, p10;
   logic [15:0] periph_status, periph_word, p16;
   logic [31:0] proc_status, proc_word, p32, r;
   logic [7:0] bscan_in, bscan_out, p8;
   logic [11:0] irv;
   logic [95:0] scan_out, d, e, w;
   logic [95:0] exp_q[$];
   jts_dbg_mode_t dbg_mode, md;
   int errors, checked, n;
   wire logic dbg_sync_n_in;
   // Open-drain sync line with pull-up.
   assign dbg_sync_n_in = ~((dbg_sync_n_oe & ~dbg_sync_n_out) | ext_low);
   jts_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .scan_done(scan_done), .scan_out(scan_out));
   jts_top #(.DBG_DEVICE_IDENTIFICATION(DBG_ID), .BSC_DEVICE_IDENTIFICATION(BSC_ID), .PRC_DEVICE_IDENTIFICATION(PRC_ID),
      .SILICON_REV(REV)) i_dut (.core_clk(core_clk), .rst(rst), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .dbg_sync_n_in(dbg_sync_n_in),
      .dbg_sync_n_out(dbg_sync_n_out), .dbg_sync_n_oe(dbg_sync_n_oe), .dbg_mode(dbg_mode),
      .breakpoint_hit(breakpoint_hit), .debug_resume(debug_resume), .debug_req(debug_req),
      .user_identifier_field(uid), .periph_status(periph_status),
      .periph_word(periph_word), .periph_stb(periph_stb), .proc_status(proc_status),
      .proc_word(proc_word), .proc_stb(proc_stb), .bscan_in(bscan_in),
      .bscan_out(bscan_out), .bscan_extest(bscan_extest));
   // Core clock, 100 ns period.
   initial begin
      core_clk = 1'h0;
      forever #50 core_clk = ~core_clk;
   end
   task end_sim();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task chk(input logic [95:0] got, input logic [95:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // An unexpected result compares against its own inverse and fails.
   task take(input logic [95:0] got);
      chk(got, exp_q.size() != 0 ? exp_q.pop_front() : ~got);
   endtask
   task expect_v(input logic [95:0] v);
      exp_q.push_back(v);
   endtask
   task wait_empty();
      for (int i = 0; i < 60 && exp_q.size() != 0; i++) begin
         @(posedge core_clk);
      end
      if (exp_q.size() != 0) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, 32'h0, exp_q.size());
         end_sim();
      end
   endtask
   function logic [95:0] rnd96();
      return {$urandom, $urandom, $urandom};
   endfunction
   task ir(input logic [11:0] v);
      expect_v(96'h111);
      i_host.scan(1'h1, 12, {84'h0, v});
   endtask
   task rd_dr(input int len, input logic [95:0] ev, input logic [95:0] wv, input logic hw);
      expect_v(ev);
      if (hw) begin
         expect_v(wv);
      end
      i_host.scan(1'h0, len, d);
      wait_empty();
   endtask
   // Results are taken off the queue as they appear.
   always @(posedge scan_done) take(scan_out);
   always @(posedge core_clk) begin
      if (periph_stb === 1'h1) take({80'h0, periph_word});
      if (proc_stb === 1'h1) take({64'h0, proc_word});
      if (debug_req === 1'h1) take(96'h1);
   end
   // Main sequence.
   initial begin
      rst = 1'h1;
      ext_low = 1'h0;
      dbg_mode = JTS_DBG_NONE;
      breakpoint_hit = 1'h0;
      debug_resume = 1'h0;
      uid = '0;
      periph_status = '0;
      proc_status = '0;
      bscan_in = '0;
      errors = 0;
      checked = 0;
      void'($urandom(51));
      i_host.tms_reset(12);
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      @(posedge core_clk);
      i_host.tms_reset(5);
      d = rnd96();
      rd_dr(96, {DBG_ID, BSC_ID, PRC_ID}, 96'h0, 1'h0);
      $display("test ident done");
      for (int u = 0; u < 2; u++) begin
         r = $urandom;
         p10 = u ? r[9:0] : 10'h000;
         @(posedge core_clk);
         uid <= p10;
         ir(12'hFF2);
         d = rnd96();
         rd_dr(34, {64'h0, p10, 6'h00, REV}, 96'h0, 1'h0);
      end
      $display("test usercode done");
      ir(12'hFFF);
      i_host.tms_reset(5);
      d = rnd96();
      rd_dr(96, {DBG_ID, BSC_ID, PRC_ID}, 96'h0, 1'h0);
      $display("test tms reset done");
      for (int k = 0; k < 4; k++) begin
         r = $urandom;
         p16 = r[15:0];
         p8 = r[23:16];
         p32 = $urandom;
         @(posedge core_clk);
         periph_status <= p16;
         proc_status <= p32;
         bscan_in <= p8;
         d = rnd96();
         w = 96'h0;
         e = {87'h0, p8, 1'h0};
         n = 10;
         irv = k == 1 ? 12'hF3F : 12'hF0F;
         if (k == 0) begin
            irv = 12'h8FF;
            n = 18;
            e = {78'h0, p16, 2'h0};
            w = {80'h0, d[17:2]};
         end else if (k == 3) begin
            irv = 12'hFF8;
            n = 34;
            e = {64'h0, p32};
            w = {64'h0, d[31:0]};
         end
         ir(irv);
         rd_dr(n, e, w, k == 0 || k == 3);
         if (k == 2) begin
            repeat (5) @(posedge core_clk); // Let the update cross.
            for (int i = 0; i < 20 && bscan_extest !== 1'h1; i++) @(posedge core_clk);
            chk(bscan_extest, 96'h1);
            chk(bscan_out, d[8:1]);
            if (bscan_extest !== 1'h1) end_sim();
         end
      end
      $display("test access done");
      for (int m = 0; m < 3; m++) begin
         md = jts_dbg_mode_t'(m);
         @(posedge core_clk);
         dbg_mode <= md;
         debug_resume <= 1'h1;
         @(posedge core_clk);
         debug_resume <= 1'h0;
         repeat (2) @(posedge core_clk);
         chk(dbg_sync_n_oe, 96'h0);
         breakpoint_hit <= 1'h1;
         @(posedge core_clk);
         breakpoint_hit <= 1'h0;
         repeat (3) @(posedge core_clk);
         chk({dbg_sync_n_oe, dbg_sync_n_in}, md == JTS_DBG_OUT ? 96'h2 : 96'h1);
         debug_resume <= 1'h1;
         @(posedge core_clk);
         debug_resume <= 1'h0;
         repeat (2) @(posedge core_clk);
         chk(dbg_sync_n_oe, 96'h0);
         if (md == JTS_DBG_IN) expect_v(96'h1);
         ext_low <= 1'h1;
         repeat (3) @(posedge core_clk);
         ext_low <= 1'h0;
         wait_empty();
         repeat (8) @(posedge core_clk);
      end
      $display("test sync pin done");
      end_sim();
   end
endmodule
`default_nettype wire
